//--- dv/rsu_dec_model.sv
`default_nettype none
module rsu_dec_model (
    input  wire logic   clk_sys_in,
    output logic        v_out,
    output logic [2:0]  s_out,
    output logic [63:0] a_out,
    output logic [63:0] b_out,
    output logic [5:0]  sh_out
);
    timeunit 1ns / 1ps;
    initial {v_out, s_out, a_out, b_out, sh_out} = '0;
    task automatic issue(logic v, logic [2:0] s, logic [63:0] a, b, logic [5:0] sh);
        @(posedge clk_sys_in);
        #1 {v_out, s_out, a_out, b_out, sh_out} = {v, s, a, b, sh};
    endtask
endmodule // rsu_dec_model
`default_nettype wire

//--- dv/rsu_props.sv
`default_nettype none
module rsu_props #(
    parameter int XLEN = 64
) (
    input wire logic            clk_sys_in,
    input wire logic            rst_n_in,
    input wire logic            op_valid_in,
    input wire logic            result_valid_out,
    input wire logic            reserved_op_out,
    input wire logic [2:0]      op_sel_in,
    input wire logic [5:0]      shamt_in,
    input wire logic [XLEN-1:0] first_source_operand_in,
    input wire logic [XLEN-1:0] result_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_lat; op_valid_in |=> result_valid_out ^ reserved_op_out; endproperty
    a_lat: assert property (p_lat) else $error("no answer");
    property p_idle; !op_valid_in |=> !result_valid_out && !reserved_op_out; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_zero; !result_valid_out |-> result_out == '0; endproperty
    a_zero: assert property (p_zero) else $error("result not zero");
    property p_none; op_valid_in && op_sel_in == 3'h4 |=> reserved_op_out; endproperty
    a_none: assert property (p_none) else $error("code not refused");
    property p_rsv; XLEN == 64 && op_valid_in && op_sel_in == 3'h0 |=> result_valid_out; endproperty
    a_rsv: assert property (p_rsv) else $error("rotate refused");
    property p_rsv32; XLEN == 32 && op_valid_in && op_sel_in == 3'h0 && shamt_in[5]
        |=> reserved_op_out && !result_valid_out; endproperty
    a_rsv32: assert property (p_rsv32) else $error("reserved rotate executed");
    property p_sext; op_valid_in && op_sel_in != 3'h0 && op_sel_in != 3'h4
        |=> result_out[XLEN-1:31] == {(XLEN-31){result_out[31]}}; endproperty
    a_sext: assert property (p_sext) else $error("no sign extension");
    property p_rot0; op_valid_in && op_sel_in == 3'h0 && shamt_in == 6'h00
        |=> result_out == $past(first_source_operand_in); endproperty
    a_rot0: assert property (p_rot0) else $error("zero rotate changed data");
    property p_sum; op_valid_in && op_sel_in inside {3'h5, 3'h7}
        && first_source_operand_in[31:0] == 32'hFFFFFFFF |=> result_out == '1; endproperty
    a_sum: assert property (p_sum) else $error("sum of ones wrong");
endmodule // rsu_props
bind rsu_rotate_hash_unit rsu_props #(.XLEN(XLEN)) u_props (
    .clk_sys_in              (clk_sys_in),
    .rst_n_in                (rst_n_in),
    .op_valid_in             (op_valid_in),
    .result_valid_out        (result_valid_out),
    .reserved_op_out         (reserved_op_out),
    .op_sel_in               (op_sel_in),
    .shamt_in                (shamt_in),
    .first_source_operand_in (first_source_operand_in),
    .result_out              (result_out)
);
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns / 1ps;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, v, rv, rsv, pv = 1'b0;
    logic [2:0] s, ps;
    logic [5:0] sh;
    logic [63:0] a, b, r, pe, st = 64'h62;
    logic rv32, rsv32, prsv32;
    logic [31:0] r32, pe32;
    int err_count = 0, tests_run = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    rsu_dec_model dec (.clk_sys_in, .v_out(v), .s_out(s), .a_out(a), .b_out(b), .sh_out(sh));
    rsu_rotate_hash_unit dut (.clk_sys_in, .rst_n_in, .op_valid_in(v), .op_sel_in(s),
        .first_source_operand_in(a), .second_source_operand_in(b), .shamt_in(sh),
        .result_valid_out(rv), .result_out(r), .reserved_op_out(rsv));
    rsu_rotate_hash_unit #(.XLEN(32)) dut32 (.clk_sys_in, .rst_n_in, .op_valid_in(v),
        .op_sel_in(s), .first_source_operand_in(a[31:0]),
        .second_source_operand_in(b[31:0]), .shamt_in(sh), .result_valid_out(rv32),
        .result_out(r32), .reserved_op_out(rsv32));
    function automatic logic [63:0] xs(logic [63:0] x);
        x ^= x << 13;
        x ^= x >> 7;
        return x ^ (x << 17);
    endfunction
    function automatic logic [31:0] rr(logic [31:0] x, int n);
        return (x >> n) | (x << (32 - n));
    endfunction
    function automatic logic [63:0] ex(logic [2:0] s, logic [63:0] a, b, logic [5:0] n);
        logic [31:0] w = a[31:0];
        case (s)
            3'h0: return (a >> n) | (a << (64 - n));
            3'h1: w = rr(w, n[4:0]);
            3'h3: w = rr(w, b[4:0]);
            3'h2: w = rr(w, 7) ^ rr(w, 18) ^ (w >> 3);
            3'h6: w = rr(w, 17) ^ rr(w, 19) ^ (w >> 10);
            3'h7: w = rr(w, 2) ^ rr(w, 13) ^ rr(w, 22);
            default: w = rr(w, 6) ^ rr(w, 11) ^ rr(w, 25);
        endcase
        return {{32{w[31]}}, w};
    endfunction
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge clk_sys_in);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        for (int i = 0; i < 601; i++) begin
            st = xs(st);
            dec.issue(i % 9 < 8 && i < 600, i < 16 ? 3'(i) : st[2:0], i < 8 ? '1 : st,
                      i < 8 ? '0 : st >> 5, i < 8 ? 6'h00 : i < 16 ? 6'h3F : st[5:0]);
            chk("result_valid_out", pv && ps != 3'h4, rv);
            chk("reserved_op_out", pv && ps == 3'h4, rsv);
            chk("result_out", pv && ps != 3'h4 ? pe : '0, r);
            chk("result_valid_out_32", pv && !prsv32, rv32);
            chk("reserved_op_out_32", pv && prsv32, rsv32);
            chk("result_out_32", pv && !prsv32 ? pe32 : '0, r32);
            pv = v;
            ps = s;
            pe = ex(s, a, b, sh);
            prsv32 = s == 3'h4 || (s == 3'h0 && sh[5]);
            pe32 = s == 3'h0 ? rr(a[31:0], sh[4:0]) : pe[31:0];
        end
        $display("test random ops done");
        wrap_up();
    end
endmodule // tb
`default_nettype wire

//--- hdl/rsu_rotate_hash_unit.sv
`default_nettype none
module rsu_rotate_hash_unit #(
    parameter int XLEN = rsu_pkg::XLEN_DEFAULT
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     op_valid_in,
    input  wire logic [rsu_pkg::OP_W-1:0] op_sel_in,
    input  wire logic [XLEN-1:0]          first_source_operand_in,
    input  wire logic [XLEN-1:0]          second_source_operand_in,
    input  wire logic [rsu_pkg::SHAMT_W-1:0] shamt_in,
    output logic                          result_valid_out,
    output logic [XLEN-1:0]               result_out,
    output logic                          reserved_op_out
);
    localparam int SHW  = $clog2(XLEN);
    localparam int WW   = rsu_pkg::WORD_W;
    localparam int WSHW = rsu_pkg::WORD_SHW;

    // Only the two base register widths are served
    if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
        $error("rsu_rotate_hash_unit: XLEN must be 32 or 64");
    end

    // Amount field must reach every rotate bit
    if (rsu_pkg::SHAMT_W < SHW) begin : g_bad_amt
        $error("rsu_rotate_hash_unit: amount field narrower than the rotate");
    end

    // Word forms need the full 32-bit low word
    if (XLEN < WW || WSHW != $clog2(WW)) begin : g_bad_word
        $error("rsu_rotate_hash_unit: word constants inconsistent");
    end

    function automatic logic [31:0] ror32(input logic [31:0] v, input logic [4:0] n);
        ror32 = (v >> n) | (v << (6'h20 - {1'b0, n}));
    endfunction

    function automatic logic [XLEN-1:0] sext(input logic [31:0] w);
        sext = XLEN'($signed(w));
    endfunction

    rsu_pkg::rsu_op_e op;
    logic [WW-1:0]    word_in;
    logic [WW-1:0]    word_res;
    logic [XLEN-1:0]  res_nxt;
    logic             rsv_nxt;
    logic             valid_nxt;
    logic             rsv_shamt;
    logic [SHW-1:0]   full_amt;
    logic [WSHW-1:0]  word_amt;
    logic [XLEN-1:0]  full_stage [SHW+1];
    logic [WW-1:0]    word_stage [WSHW+1];
    logic [XLEN-1:0]  full_rot;
    logic [WW-1:0]    word_rot;
    logic [WW-1:0]    hash_small_sigma_zero;
    logic [WW-1:0]    hash_small_sigma_one;
    logic [WW-1:0]    hash_big_sum_zero;
    logic [WW-1:0]    hash_big_sum_one;
    logic             result_valid_r;
    logic             reserved_r;
    logic [XLEN-1:0]  result_r;

    assign op      = rsu_pkg::rsu_op_e'(op_sel_in);
    assign word_in = first_source_operand_in[WW-1:0];

    // Full-width amount for the plain rotate
    assign full_amt  = shamt_in[SHW-1:0];
    assign rsv_shamt = (XLEN == 32) && shamt_in[rsu_pkg::RSV_SHAMT_BIT];

    // Word forms take five amount bits
    always_comb begin
        if (op == rsu_pkg::RSU_OP_ROR_REG_W) begin
            word_amt = second_source_operand_in[WSHW-1:0];
        end else begin
            word_amt = shamt_in[WSHW-1:0];
        end
    end

    // Log-depth rotate right, one stage per amount bit
    assign full_stage[0] = first_source_operand_in;
    for (genvar k = 0; k < SHW; k++) begin : g_full_rot
        localparam int STEP = 1 << k;
        assign full_stage[k+1] = full_amt[k]
                               ? {full_stage[k][STEP-1:0], full_stage[k][XLEN-1:STEP]}
                               : full_stage[k];
    end
    assign full_rot = full_stage[SHW];

    assign word_stage[0] = word_in;
    for (genvar k = 0; k < WSHW; k++) begin : g_word_rot
        localparam int STEP = 1 << k;
        assign word_stage[k+1] = word_amt[k]
                               ? {word_stage[k][STEP-1:0], word_stage[k][WW-1:STEP]}
                               : word_stage[k];
    end
    assign word_rot = word_stage[WSHW];

    // Hash transforms on the low word only
    assign hash_small_sigma_zero = ror32(word_in, 5'(rsu_pkg::SIG0_R1))
                                 ^ ror32(word_in, 5'(rsu_pkg::SIG0_R2))
                                 ^ (word_in >> rsu_pkg::SIG0_SH);

    assign hash_small_sigma_one = ror32(word_in, 5'(rsu_pkg::SIG1_R1))
                                ^ ror32(word_in, 5'(rsu_pkg::SIG1_R2))
                                ^ (word_in >> rsu_pkg::SIG1_SH);

    assign hash_big_sum_zero = ror32(word_in, 5'(rsu_pkg::SUM0_R1))
                             ^ ror32(word_in, 5'(rsu_pkg::SUM0_R2))
                             ^ ror32(word_in, 5'(rsu_pkg::SUM0_R3));

    assign hash_big_sum_one = ror32(word_in, 5'(rsu_pkg::SUM1_R1))
                            ^ ror32(word_in, 5'(rsu_pkg::SUM1_R2))
                            ^ ror32(word_in, 5'(rsu_pkg::SUM1_R3));

    // Refusal decode, kept apart from the result path
    always_comb begin
        case (op)
            rsu_pkg::RSU_OP_ROR_IMM: begin
                rsv_nxt = rsv_shamt;
            end
            rsu_pkg::RSU_OP_ROR_IMM_W,
            rsu_pkg::RSU_OP_ROR_REG_W,
            rsu_pkg::RSU_OP_SIG0,
            rsu_pkg::RSU_OP_SIG1,
            rsu_pkg::RSU_OP_SUM0,
            rsu_pkg::RSU_OP_SUM1: begin
                rsv_nxt = 1'b0;
            end
            default: begin
                rsv_nxt = 1'b1;
            end
        endcase
    end

    // Result select, word forms sign-extended
    always_comb begin
        word_res = '0;
        res_nxt  = '0;
        case (op)
            rsu_pkg::RSU_OP_ROR_IMM: begin
                res_nxt = full_rot;
            end
            rsu_pkg::RSU_OP_ROR_IMM_W: begin
                word_res = word_rot;
                res_nxt  = sext(word_res);
            end
            rsu_pkg::RSU_OP_ROR_REG_W: begin
                word_res = word_rot;
                res_nxt  = sext(word_res);
            end
            rsu_pkg::RSU_OP_SIG0: begin
                word_res = hash_small_sigma_zero;
                res_nxt  = sext(word_res);
            end
            rsu_pkg::RSU_OP_SIG1: begin
                word_res = hash_small_sigma_one;
                res_nxt  = sext(word_res);
            end
            rsu_pkg::RSU_OP_SUM0: begin
                word_res = hash_big_sum_zero;
                res_nxt  = sext(word_res);
            end
            rsu_pkg::RSU_OP_SUM1: begin
                word_res = hash_big_sum_one;
                res_nxt  = sext(word_res);
            end
            default: begin
                res_nxt = '0;
            end
        endcase
    end

    assign valid_nxt = op_valid_in & ~rsv_nxt;

    // Fixed single-cycle answer, no data-dependent stall
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_valid_r <= 1'b0;
        end else begin
            result_valid_r <= valid_nxt;
        end
    end

    // One-cycle refusal pulse
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reserved_r <= 1'b0;
        end else begin
            reserved_r <= op_valid_in & rsv_nxt;
        end
    end

    // Result held at zero unless a request is accepted
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_r <= '0;
        end else if (valid_nxt) begin
            result_r <= res_nxt;
        end else begin
            result_r <= '0;
        end
    end

    // Outputs straight from the flops
    assign result_valid_out = result_valid_r;
    assign reserved_op_out  = reserved_r;
    assign result_out       = result_r;
endmodule // rsu_rotate_hash_unit
`default_nettype wire

//--- shared/rsu_pkg.sv
`default_nettype none
package rsu_pkg;
    localparam int XLEN_DEFAULT = 64;
    localparam int WORD_W       = 32;
    localparam int WORD_SHW     = 5;
    localparam int OP_W         = 3;
    localparam int SHAMT_W      = 6;
    localparam int LATENCY      = 1;

    // Operation select, Gray coded along the listed order
    typedef enum logic [2:0] {
        RSU_OP_ROR_IMM   = 3'h0,
        RSU_OP_ROR_IMM_W = 3'h1,
        RSU_OP_ROR_REG_W = 3'h3,
        RSU_OP_SIG0      = 3'h2,
        RSU_OP_SIG1      = 3'h6,
        RSU_OP_SUM0      = 3'h7,
        RSU_OP_SUM1      = 3'h5,
        RSU_OP_NONE      = 3'h4
    } rsu_op_e;

    localparam int SIG0_R1 = 7;
    localparam int SIG0_R2 = 18;
    localparam int SIG0_SH = 3;
    localparam int SIG1_R1 = 17;
    localparam int SIG1_R2 = 19;
    localparam int SIG1_SH = 10;
    localparam int SUM0_R1 = 2;
    localparam int SUM0_R2 = 13;
    localparam int SUM0_R3 = 22;
    localparam int SUM1_R1 = 6;
    localparam int SUM1_R2 = 11;
    localparam int SUM1_R3 = 25;
    localparam int RSV_SHAMT_BIT = 5;
endpackage
`default_nettype wire
